//--- bench/dadc_capture.sv
/*
 Capturing logic on the far side of both parallel buses.
 Assumes the pads are sampled on clk_i and that a released pad
 floats, so it shows a value that keeps changing.
*/
`timescale 1ns/1ps
module dadc_capture (
  input wire logic clk_i,
  input wire logic [dadc_pkg::WORD_W-1:0] word_a_i,
  input wire logic ovr_a_i,
  input wire logic oe_n_a_i,
  input wire logic [dadc_pkg::WORD_W-1:0] word_b_i,
  input wire logic ovr_b_i,
  input wire logic oe_n_b_i,
  output logic [dadc_pkg::WORD_W:0] cap_a_o,
  output logic [dadc_pkg::WORD_W:0] cap_b_o
);
  import dadc_pkg::*;
  logic [WORD_W:0] pad_a, pad_b, last_a_q, last_b_q;
  // Floating pad toggles so a stale value is never mistaken for data
  assign pad_a = oe_n_a_i ? ~last_a_q : {word_a_i, ovr_a_i};
  assign pad_b = oe_n_b_i ? ~last_b_q : {word_b_i, ovr_b_i};
  always_ff @(posedge clk_i) begin
    last_a_q <= pad_a;
    last_b_q <= pad_b;
    if (!oe_n_a_i) begin
      cap_a_o <= pad_a;
    end
    if (!oe_n_b_i) begin
      cap_b_o <= pad_b;
    end
  end
endmodule

//--- bench/tb_dual_adc_output_control.sv
/*
 Self-checking bench for the dual converter output control block.
 Assumes one 20 MHz clock, pins driven by the bench and a capture
 model reading both buses.
*/
`timescale 1ns/1ps
module tb_dual_adc_output_control;
  import dadc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic ack, irq, twos, dcs, oe_a, oe_b, ovr_a, ovr_b;
  logic [1:0] cfg = 2'h0;
  logic pd_a = 1'b0, pd_b = 1'b0, oeb_a = 1'b0, oeb_b = 1'b0;
  logic swap = 1'b1;
  dadc_raw_t raw_a = '0, raw_b = '0;
  logic [WORD_W-1:0] word_a, word_b;
  logic [WORD_W:0] cap_a, cap_b;
  int err_total = 0;
  int compares = 0;
  int vals[6] = '{0, 5, -1, 9000, -9000, 8191};

  always #25 clk_i = ~clk_i;

  dadc_top #(.SLEEP_WAKE(50), .NAP_WAKE(10), .RELOCK(10),
    .IDLE_LIM(20)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .cfg_level_i(cfg),
    .chan_a_power_down_i(pd_a), .chan_b_power_down_i(pd_b),
    .chan_a_output_enable_bar_i(oeb_a),
    .chan_b_output_enable_bar_i(oeb_b),
    .bus_swap_select_i(swap), .chan_a_raw_i(raw_a),
    .chan_b_raw_i(raw_b), .bus_a_word_o(word_a),
    .bus_a_overrange_o(ovr_a), .bus_a_oe_n_o(oe_a),
    .bus_b_word_o(word_b), .bus_b_overrange_o(ovr_b),
    .bus_b_oe_n_o(oe_b), .twos_format_o(twos), .dcs_enable_o(dcs),
    .irq_o(irq));

  dadc_capture cap (
    .clk_i(clk_i), .word_a_i(word_a), .ovr_a_i(ovr_a),
    .oe_n_a_i(oe_a), .word_b_i(word_b), .ovr_b_i(ovr_b),
    .oe_n_b_i(oe_b), .cap_a_o(cap_a), .cap_b_o(cap_b));

  task stop_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      err_total++;
      stop_test();
    end
  endtask

  task rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(nm, rdat, exp);
  endtask

  // Pins pass two sync flops and two registers before the pads move
  task settle();
    repeat (8) @(posedge clk_i);
  endtask

  task smp(input int va, input int vb);
    @(posedge clk_i);
    raw_a <= '{1'b1, 16'(va)};
    raw_b <= '{1'b1, 16'(vb)};
    @(posedge clk_i);
    raw_a.valid <= 1'b0;
    raw_b.valid <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  function automatic logic [WORD_W:0] fmt(input int v, input logic tw);
    int s;
    logic [WORD_W-1:0] w;
    s = v > int'(CODE_MAX) ? int'(CODE_MAX) : v;
    s = s < int'(CODE_MIN) ? int'(CODE_MIN) : s;
    w = s[WORD_W-1:0];
    if (!tw) w[WORD_W-1] = ~w[WORD_W-1];
    return {w, v != s};
  endfunction

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    rd(REG_IRQ_MASK, 32'h0, "mask reset");
    // enables stay steady while samples stream
    for (int l = 0; l < 4; l++) begin
      @(posedge clk_i);
      cfg <= 2'(l);
      settle();
      chk("twos", twos, l >= 2);
      chk("dcs", dcs, l == 1 || l == 2);
      foreach (vals[i]) begin
        smp(vals[i], vals[i]);
        chk("bus a", cap_a, fmt(vals[i], l >= 2));
        chk("bus b", cap_b, fmt(vals[i], l >= 2));
      end
    end
    // swap held static; shared-bus toggling left to the system
    @(posedge clk_i);
    cfg <= 2'h0;
    swap <= 1'b0;
    settle();
    smp(100, -100);
    chk("swap a", cap_a, fmt(-100, 1'b0));
    chk("swap b", cap_b, fmt(100, 1'b0));
    @(posedge clk_i);
    swap <= 1'b1;
    oeb_b <= 1'b1;
    settle();
    smp(200, -200);
    chk("straight a", cap_a, fmt(200, 1'b0));
    chk("oe b", oe_b, 1'b1);
    chk("oe a", oe_a, 1'b0);
    @(posedge clk_i);
    oeb_b <= 1'b0;
    pd_a <= 1'b1;
    settle();
    wb(1'b0, REG_STATUS, 32'h0, 4'hf);
    chk("nap mode", rdat[3:0], 4'h1);
    chk("nap oe", oe_a, 1'b1);
    smp(300, 300);
    chk("b runs", cap_b, fmt(300, 1'b0));
    @(posedge clk_i);
    oeb_a <= 1'b1;
    settle();
    wb(1'b0, REG_STATUS, 32'h0, 4'hf);
    chk("sleep mode", rdat[1:0], 2'h2);
    @(posedge clk_i);
    pd_a <= 1'b0;
    oeb_a <= 1'b0;
    settle();
    wb(1'b0, REG_STATUS, 32'h0, 4'hf);
    chk("normal", rdat[1:0], 2'h0);
    chk("sleep wake", rdat[4], 1'b0);
    repeat (60) @(posedge clk_i);
    wb(1'b0, REG_STATUS, 32'h0, 4'hf);
    chk("sleep ready", rdat[4], 1'b1);
    @(posedge clk_i);
    pd_a <= 1'b1;
    settle();
    @(posedge clk_i);
    pd_a <= 1'b0;
    settle();
    repeat (8) smp(1, 1);
    wb(1'b0, REG_STATUS, 32'h0, 4'hf);
    chk("nap wake", rdat[4], 1'b0);
    repeat (2) smp(1, 1);
    wb(1'b0, REG_STATUS, 32'h0, 4'hf);
    chk("nap ready", rdat[4], 1'b1);
    // Stabilizer on, samples stopped past the idle limit, then restarted
    @(posedge clk_i);
    cfg <= 2'h1;
    repeat (30) @(posedge clk_i);
    smp(1, 1);
    wb(1'b0, REG_STATUS, 32'h0, 4'hf);
    chk("relock", rdat[5:4], 2'h0);
    repeat (10) smp(1, 1);
    wb(1'b0, REG_STATUS, 32'h0, 4'hf);
    chk("relocked", rdat[5:4], 2'h3);
    @(posedge clk_i);
    cfg <= 2'h0;
    settle();
    wb(1'b1, REG_IRQ_STS, 32'hf, 4'hf);
    rd(REG_IRQ_STS, 32'h0, "sts clear");
    wb(1'b1, REG_IRQ_MASK, 32'h1, 4'h0);
    rd(REG_IRQ_MASK, 32'h0, "sel refused");
    wb(1'b1, REG_IRQ_MASK, 32'h1, 4'hf);
    rd(REG_IRQ_MASK, 32'h1, "mask");
    smp(9000, 0);
    rd(REG_IRQ_STS, 32'h1, "ovr a sts");
    chk("irq on", irq, 1'b1);
    wb(1'b1, REG_IRQ_STS, 32'h1, 4'hf);
    smp(0, -9000);
    rd(REG_IRQ_STS, 32'h2, "ovr b sts");
    chk("irq masked", irq, 1'b0);
    rd(4'hc, 32'h0, "unmapped");
    stop_test();
  end
endmodule

//--- rtl/dadc_chan.sv
/*
 One converter channel: power mode, wake timing and output word format.
 Assumes its pin inputs are already synchronised to clk_i and raw
 samples arrive as one-cycle valid strobes from the converter core.
*/
`timescale 1ns/1ps
module dadc_chan #(
  parameter int SLEEP_WAKE = dadc_pkg::SLEEP_WAKE_CYC,
  parameter int NAP_WAKE = dadc_pkg::NAP_WAKE_SMP,
  parameter int RELOCK = dadc_pkg::RELOCK_SMP,
  parameter int IDLE_LIM = dadc_pkg::IDLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pd_i,
  input wire logic oeb_i,
  input wire logic twos_i,
  input wire logic dcs_i,
  input dadc_pkg::dadc_raw_t raw_i,
  output dadc_pkg::dadc_out_t out_o,
  output logic drive_o,
  output logic ready_o,
  output dadc_pkg::dadc_pmode_t mode_o,
  output logic ovr_evt_o,
  output logic ready_evt_o
);
  import dadc_pkg::*;

  dadc_pmode_t mode_q, mode_d;
  logic [CNT_W-1:0] wait_q, wait_d, idle_q, idle_d;
  logic by_smp_q, by_smp_d, drive_q, drive_d, ready_q, ready_d;
  logic ovr_evt_q, ovr_evt_d, rdy_evt_q, rdy_evt_d;
  dadc_out_t out_q, out_d;
  logic signed [RAW_W-1:0] code;
  logic ovr;

  always_comb begin
    if (!pd_i) begin
      mode_d = PM_NORMAL;
    end else if (oeb_i) begin
      mode_d = PM_SLEEP;
    end else begin
      mode_d = PM_NAP;
    end
    drive_d = (mode_d == PM_NORMAL) && !oeb_i;
    idle_d = raw_i.valid ? '0 :
      (idle_q >= CNT_W'(IDLE_LIM)) ? idle_q : idle_q + 1'b1;
    wait_d = wait_q;
    by_smp_d = by_smp_q;
    if (mode_q == PM_SLEEP && mode_d == PM_NORMAL) begin
      // reference recharge counted in system clocks
      wait_d = CNT_W'(SLEEP_WAKE);
      by_smp_d = 1'b0;
    end else if (mode_q == PM_NAP && mode_d == PM_NORMAL) begin
      wait_d = CNT_W'(NAP_WAKE);
      by_smp_d = 1'b1;
    end else if (dcs_i && raw_i.valid && idle_q >= CNT_W'(IDLE_LIM)) begin
      // sample clock restarted, loop must relock
      wait_d = CNT_W'(RELOCK);
      by_smp_d = 1'b1;
    end else if (wait_q != '0 && (raw_i.valid || !by_smp_q)) begin
      wait_d = wait_q - 1'b1;
    end
    ready_d = (mode_d == PM_NORMAL) && (wait_d == '0);
    rdy_evt_d = ready_d && !ready_q;
    if (raw_i.value > CODE_MAX) begin
      code = CODE_MAX;
      ovr = 1'b1;
    end else if (raw_i.value < CODE_MIN) begin
      code = CODE_MIN;
      ovr = 1'b1;
    end else begin
      code = raw_i.value;
      ovr = 1'b0;
    end
    out_d = out_q;
    ovr_evt_d = 1'b0;
    // one strobe per rising sample edge, falling edge unused
    if (raw_i.valid && mode_q == PM_NORMAL) begin
      // offset binary flips the sign bit
      out_d.word = twos_i ? code[WORD_W-1:0] :
        {~code[WORD_W-1], code[WORD_W-2:0]};
      out_d.ovr = ovr;
      ovr_evt_d = ovr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= PM_NORMAL;
      wait_q <= '0;
      idle_q <= '0;
      by_smp_q <= 1'b0;
      drive_q <= 1'b0;
      ready_q <= 1'b0;
      ovr_evt_q <= 1'b0;
      rdy_evt_q <= 1'b0;
      out_q <= '0;
    end else begin
      mode_q <= mode_d;
      wait_q <= wait_d;
      idle_q <= idle_d;
      by_smp_q <= by_smp_d;
      drive_q <= drive_d;
      ready_q <= ready_d;
      ovr_evt_q <= ovr_evt_d;
      rdy_evt_q <= rdy_evt_d;
      out_q <= out_d;
    end
  end

  assign out_o = out_q;
  assign drive_o = drive_q;
  assign ready_o = ready_q;
  assign mode_o = mode_q;
  assign ovr_evt_o = ovr_evt_q;
  assign ready_evt_o = rdy_evt_q;

  a_low_power_float: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pd_i ##1 pd_i |-> !drive_q)
    else $error("output driven in low-power mode");

  a_nap_wake_load: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_q == PM_NAP && !pd_i) |=> wait_q == CNT_W'(NAP_WAKE) && !ready_q)
    else $error("nap exit did not load sample count");

  a_sleep_wake_load: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_q == PM_SLEEP && !pd_i) |=> wait_q == CNT_W'(SLEEP_WAKE))
    else $error("sleep exit did not load clock count");

  a_sat_high_code: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (raw_i.valid && mode_q == PM_NORMAL && raw_i.value > CODE_MAX)
    |=> out_q.ovr && out_q.word == ($past(twos_i) ? 14'h1fff : 14'h3fff))
    else $error("over-range sample not saturated");

  a_mid_scale: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (raw_i.valid && mode_q == PM_NORMAL && raw_i.value == '0)
    |=> !out_q.ovr && out_q.word == ($past(twos_i) ? 14'h0000 : 14'h2000))
    else $error("mid-scale code wrong for format");
endmodule

//--- rtl/dadc_pkg.sv
/*
 Shared constants, types and decode helpers for the dual converter
 output control block.
 Assumes one system clock and a synchronous active-high reset.
*/
// Contract
// - Low config levels give offset binary, high two's complement
// - Stabilizer on only at the two middle levels
// - One config input serves both channels
// - Overflow flag high when input is out of range
// - Enable bar high floats data and flag
// - Each channel has its own output enable
// - Power-down low means normal conversion
// - Power-down and enable bar high: sleep, slow wake
// - Power-down high, enable bar low: nap, 100-sample wake
// - Sleep and nap float all channel outputs
// - Each channel's mode follows only its pins
// - Swap select high keeps buses straight, low swaps
// - Mid-scale codes fixed; out of range saturates
// - Stabilizer samples on rising edge only
// - Stabilizer relocks over 100 samples after clock stop
package dadc_pkg;
  localparam int WORD_W = 14;
  localparam int RAW_W = 16;
  localparam int CNT_W = 16;
  localparam logic signed [RAW_W-1:0] CODE_MAX = 16'sh1fff;
  localparam logic signed [RAW_W-1:0] CODE_MIN = 16'she000;
  localparam int CLK_MHZ = 20;
  localparam int SLEEP_WAKE_US = 2000;
  localparam int SLEEP_WAKE_CYC = SLEEP_WAKE_US * CLK_MHZ;
  localparam int NAP_WAKE_SMP = 100;
  localparam int RELOCK_SMP = 100;
  localparam int IDLE_US = 10;
  localparam int IDLE_CYC = IDLE_US * CLK_MHZ;
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_THIRD = 2'h1;
  localparam logic [1:0] LVL_TWO_THIRDS = 2'h2;
  localparam logic [1:0] LVL_VDD = 2'h3;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_IRQ_STS = 4'h4;
  localparam logic [3:0] REG_IRQ_MASK = 4'h8;
  localparam int ST_MODE_A = 0;
  localparam int ST_MODE_B = 2;
  localparam int ST_READY_A = 4;
  localparam int ST_READY_B = 5;
  localparam int ST_TWOS = 6;
  localparam int ST_DCS = 7;
  localparam int ST_SWAP = 8;
  localparam int IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_NAP = 2'b01,
    PM_SLEEP = 2'b10
  } dadc_pmode_t;

  typedef struct packed {
    logic valid;
    logic signed [RAW_W-1:0] value;
  } dadc_raw_t;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic ovr;
  } dadc_out_t;

  function automatic logic fmt_twos(input logic [1:0] lvl);
    return (lvl == LVL_TWO_THIRDS) || (lvl == LVL_VDD);
  endfunction

  function automatic logic dcs_on(input logic [1:0] lvl);
    return (lvl == LVL_THIRD) || (lvl == LVL_TWO_THIRDS);
  endfunction
endpackage

//--- rtl/dadc_top.sv
/*
 Output control of a dual 14-bit converter: format and stabilizer
 decode, per-channel power modes, bus swap, pad enables, and a
 classic Wishbone slave with status and interrupt registers.
 Assumes pins are asynchronous and passes them through two flip-flops;
 raw sample strobes come from core logic on clk_i.
*/
`timescale 1ns/1ps
module dadc_top #(
  parameter int SLEEP_WAKE = dadc_pkg::SLEEP_WAKE_CYC,
  parameter int NAP_WAKE = dadc_pkg::NAP_WAKE_SMP,
  parameter int RELOCK = dadc_pkg::RELOCK_SMP,
  parameter int IDLE_LIM = dadc_pkg::IDLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] cfg_level_i,
  input wire logic chan_a_power_down_i,
  input wire logic chan_b_power_down_i,
  input wire logic chan_a_output_enable_bar_i,
  input wire logic chan_b_output_enable_bar_i,
  input wire logic bus_swap_select_i,
  input dadc_pkg::dadc_raw_t chan_a_raw_i,
  input dadc_pkg::dadc_raw_t chan_b_raw_i,
  output logic [dadc_pkg::WORD_W-1:0] bus_a_word_o,
  output logic bus_a_overrange_o,
  output logic bus_a_oe_n_o,
  output logic [dadc_pkg::WORD_W-1:0] bus_b_word_o,
  output logic bus_b_overrange_o,
  output logic bus_b_oe_n_o,
  output logic twos_format_o,
  output logic dcs_enable_o,
  output logic irq_o
);
  import dadc_pkg::*;

  // Every count must fit the shared counter width and be non-zero
  if (SLEEP_WAKE < 1 || SLEEP_WAKE >= (1 << CNT_W) ||
      NAP_WAKE < 1 || NAP_WAKE >= (1 << CNT_W) ||
      RELOCK < 1 || RELOCK >= (1 << CNT_W) ||
      IDLE_LIM < 1 || IDLE_LIM >= (1 << CNT_W)) begin : g_bad_count
    $error("dadc_top: count parameter out of range");
  end

  // Pin synchronisers; stage one is read only by stage two
  localparam int SYN_W = 7;
  logic [SYN_W-1:0] pin_raw, syn1_q, syn1_d, syn2_q, syn2_d;
  logic [1:0] lvl, lvl_raw, lvl_prev_q, lvl_prev_d, lvl_q, lvl_d;
  logic pd_a, pd_b, oeb_a, oeb_b, swap;

  assign pin_raw = {cfg_level_i, chan_a_power_down_i, chan_b_power_down_i,
    chan_a_output_enable_bar_i, chan_b_output_enable_bar_i,
    bus_swap_select_i};
  assign {lvl_raw, pd_a, pd_b, oeb_a, oeb_b, swap} = syn2_q;
  assign lvl = lvl_q;

  always_comb begin
    syn1_d = pin_raw;
    syn2_d = syn1_q;
    // The level is a two-bit word: take it only once it repeats, so bits
    // that cross a sync edge apart never decode a false level
    lvl_prev_d = lvl_raw;
    lvl_d = (lvl_raw == lvl_prev_q) ? lvl_raw : lvl_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      syn1_q <= '0;
      syn2_q <= '0;
      lvl_prev_q <= LVL_GND;
      lvl_q <= LVL_GND;
    end else begin
      syn1_q <= syn1_d;
      syn2_q <= syn2_d;
      lvl_prev_q <= lvl_prev_d;
      lvl_q <= lvl_d;
    end
  end

  // one decode shared by both channels
  logic twos_d, twos_q, dcs_d, dcs_q;
  always_comb begin
    twos_d = fmt_twos(lvl);
    dcs_d = dcs_on(lvl);
  end

  dadc_out_t a_out, b_out;
  logic a_drive, b_drive, a_ready, b_ready;
  logic a_ovr_evt, b_ovr_evt, a_rdy_evt, b_rdy_evt;
  dadc_pmode_t a_mode, b_mode;

  dadc_chan #(
    .SLEEP_WAKE(SLEEP_WAKE),
    .NAP_WAKE(NAP_WAKE),
    .RELOCK(RELOCK),
    .IDLE_LIM(IDLE_LIM)
  ) u_chan_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pd_i(pd_a),
    .oeb_i(oeb_a),
    .twos_i(twos_q),
    .dcs_i(dcs_q),
    .raw_i(chan_a_raw_i),
    .out_o(a_out),
    .drive_o(a_drive),
    .ready_o(a_ready),
    .mode_o(a_mode),
    .ovr_evt_o(a_ovr_evt),
    .ready_evt_o(a_rdy_evt)
  );

  dadc_chan #(
    .SLEEP_WAKE(SLEEP_WAKE),
    .NAP_WAKE(NAP_WAKE),
    .RELOCK(RELOCK),
    .IDLE_LIM(IDLE_LIM)
  ) u_chan_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pd_i(pd_b),
    .oeb_i(oeb_b),
    .twos_i(twos_q),
    .dcs_i(dcs_q),
    .raw_i(chan_b_raw_i),
    .out_o(b_out),
    .drive_o(b_drive),
    .ready_o(b_ready),
    .mode_o(b_mode),
    .ovr_evt_o(b_ovr_evt),
    .ready_evt_o(b_rdy_evt)
  );

  // Pad stage: each bus takes the enable of the channel it carries
  dadc_out_t bus_a_q, bus_a_d, bus_b_q, bus_b_d;
  logic oe_a_n_q, oe_a_n_d, oe_b_n_q, oe_b_n_d;
  always_comb begin
    if (swap) begin
      bus_a_d = a_out;
      bus_b_d = b_out;
      oe_a_n_d = !a_drive;
      oe_b_n_d = !b_drive;
    end else begin
      bus_a_d = b_out;
      bus_b_d = a_out;
      oe_a_n_d = !b_drive;
      oe_b_n_d = !a_drive;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_a_q <= '0;
      bus_b_q <= '0;
      oe_a_n_q <= 1'b1;
      oe_b_n_q <= 1'b1;
      twos_q <= 1'b0;
      dcs_q <= 1'b0;
    end else begin
      bus_a_q <= bus_a_d;
      bus_b_q <= bus_b_d;
      oe_a_n_q <= oe_a_n_d;
      oe_b_n_q <= oe_b_n_d;
      twos_q <= twos_d;
      dcs_q <= dcs_d;
    end
  end

  // Wishbone slave, one wait state, unmapped reads return zero
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [IRQ_W-1:0] sts_q, sts_d, mask_q, mask_d, evt, clr;
  logic irq_q, irq_d;
  logic req, wr;

  always_comb begin
    req = wb_cyc_i && wb_stb_i && !ack_q;
    wr = req && wb_we_i && wb_sel_i[0];
    ack_d = req;
    evt = '0;
    evt[0] = a_ovr_evt;
    evt[1] = b_ovr_evt;
    evt[2] = a_rdy_evt;
    evt[3] = b_rdy_evt;
    clr = (wr && wb_adr_i == REG_IRQ_STS) ? wb_dat_i[IRQ_W-1:0] : '0;
    // A new event beats a clear in the same cycle
    sts_d = (sts_q & ~clr) | evt;
    mask_d = (wr && wb_adr_i == REG_IRQ_MASK) ?
      wb_dat_i[IRQ_W-1:0] : mask_q;
    irq_d = |(sts_d & mask_d);
    rdat_d = '0;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        REG_STATUS: begin
          rdat_d[ST_MODE_A +: 2] = a_mode;
          rdat_d[ST_MODE_B +: 2] = b_mode;
          rdat_d[ST_READY_A] = a_ready;
          rdat_d[ST_READY_B] = b_ready;
          rdat_d[ST_TWOS] = twos_q;
          rdat_d[ST_DCS] = dcs_q;
          rdat_d[ST_SWAP] = swap;
        end
        REG_IRQ_STS: begin
          rdat_d[IRQ_W-1:0] = sts_q;
        end
        REG_IRQ_MASK: begin
          rdat_d[IRQ_W-1:0] = mask_q;
        end
        default: begin
          rdat_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
      sts_q <= '0;
      mask_q <= IRQ_MASK_RST;
      irq_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      sts_q <= sts_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign irq_o = irq_q;
  assign bus_a_word_o = bus_a_q.word;
  assign bus_a_overrange_o = bus_a_q.ovr;
  assign bus_a_oe_n_o = oe_a_n_q;
  assign bus_b_word_o = bus_b_q.word;
  assign bus_b_overrange_o = bus_b_q.ovr;
  assign bus_b_oe_n_o = oe_b_n_q;
  assign twos_format_o = twos_q;
  assign dcs_enable_o = dcs_q;

  a_dcs_level_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 dcs_enable_o == ($past(lvl) == LVL_THIRD ||
      $past(lvl) == LVL_TWO_THIRDS))
    else $error("stabilizer enable does not match level");

  a_fmt_level_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 twos_format_o == $past(lvl[1]))
    else $error("format select does not match level");

  a_swap_straight: assert property (
    @(posedge clk_i) disable iff (rst_i)
    swap |=> bus_a_word_o == $past(a_out.word) &&
      bus_b_overrange_o == $past(b_out.ovr))
    else $error("straight routing broken");

  a_swap_cross: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !swap |=> bus_b_word_o == $past(a_out.word) &&
      bus_a_oe_n_o == !$past(b_drive))
    else $error("swapped routing broken");

  a_oe_bar_float: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (oeb_a && swap)[*3] |-> bus_a_oe_n_o)
    else $error("bus driven while enable bar high");

  a_ack_one_cycle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_irq_follows: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 irq_o == |(sts_q & mask_q))
    else $error("interrupt level disagrees with status");

  a_ovr_sticky: assert property (
    @(posedge clk_i) disable iff (rst_i)
    a_ovr_evt |=> sts_q[0])
    else $error("overflow event lost");

  a_ovr_b_sticky: assert property (
    @(posedge clk_i) disable iff (rst_i)
    b_ovr_evt |=> sts_q[1])
    else $error("channel b overflow event lost");

  a_oe_b_float: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (oeb_b && swap)[*3] |-> bus_b_oe_n_o)
    else $error("bus b driven while its enable bar high");

  a_ack_after_req: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
endmodule
